// File: design/bsr_pkg.sv
// Package for the bank-one special register map: register indices,
// field positions, per-slot write masks and reset tables.
// Assumes indices are word indices; byte address is four times index.
package bsr_pkg;

  localparam int ADDR_W = 11;
  localparam int IDX_W = 9;
  localparam int SLOT_W = 5;
  localparam int NUM_SLOTS = 32;

  // Register indices as printed (byte address = 4 * index)
  localparam logic [8:0] IDX_INDIRECT_ACCESS_PORT = 9'h080;
  localparam logic [8:0] IDX_TIMER0_AND_PORTB_OPTIONS = 9'h081;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_LOW = 9'h082;
  localparam logic [8:0] IDX_CPU_STATUS_FLAGS = 9'h083;
  localparam logic [8:0] IDX_INDIRECT_POINTER = 9'h084;
  localparam logic [8:0] IDX_PORT_A_DIRECTION = 9'h085;
  localparam logic [8:0] IDX_PORT_B_DIRECTION = 9'h086;
  localparam logic [8:0] IDX_PORT_C_DIRECTION = 9'h087;
  localparam logic [8:0] IDX_FOURTH_PORT_DIRECTION = 9'h088;
  localparam logic [8:0] IDX_FIFTH_PORT_DIRECTION_STATUS = 9'h089;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_UPPER_LATCH = 9'h08A;
  localparam logic [8:0] IDX_INTERRUPT_CONTROL = 9'h08B;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_ONE = 9'h08C;
  localparam logic [8:0] IDX_PERIPHERAL_IRQ_ENABLE_TWO = 9'h08D;
  localparam logic [8:0] IDX_POWER_RESET_CAUSE_FLAGS = 9'h08E;
  localparam logic [8:0] IDX_TIMER2_PERIOD = 9'h092;
  localparam logic [8:0] IDX_SERIAL_PORT_SLAVE_ADDRESS = 9'h093;
  localparam logic [8:0] IDX_SERIAL_PORT_STATE = 9'h094;
  localparam logic [8:0] IDX_USART_TRANSMIT_CONTROL = 9'h098;
  localparam logic [8:0] IDX_BAUD_RATE_DIVISOR = 9'h099;
  localparam logic [8:0] IDX_CONVERTER_PIN_CONFIG = 9'h09F;

  // Index fields
  localparam logic [1:0] BANK_ONE = 2'h1;
  localparam logic [1:0] SFR_REGION = 2'h0;

  // Field positions
  localparam int STATUS_IRP_BIT = 7;
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam int PROGRAM_COUNTER_UPPER_LATCH_W = 5;
  localparam int PCL_W = 8;
  localparam int FIFTH_PORT_DIRECTION_STATUS_LIVE_LSB = 5;
  localparam int SERIAL_PORT_STATE_LIVE_W = 6;
  localparam int USART_TRANSMIT_CONTROL_SHIFT_EMPTY_BIT = 1;

  // Registers that decode the same from every bank
  function automatic logic slot_common(input logic [4:0] s);
    case (s)
      IDX_INDIRECT_ACCESS_PORT[4:0], IDX_PROGRAM_COUNTER_LOW[4:0],
      IDX_CPU_STATUS_FLAGS[4:0], IDX_INDIRECT_POINTER[4:0],
      IDX_PROGRAM_COUNTER_UPPER_LATCH[4:0],
      IDX_INTERRUPT_CONTROL[4:0]: slot_common = 1'b1;
      default: slot_common = 1'b0;
    endcase
  endfunction

  // Bits software may write; zero for unimplemented slots and bits
  function automatic logic [7:0] slot_wmask(input logic [4:0] s);
    case (s)
      IDX_CPU_STATUS_FLAGS[4:0]: slot_wmask = 8'hE7;
      IDX_PORT_A_DIRECTION[4:0]: slot_wmask = 8'h3F;
      IDX_FIFTH_PORT_DIRECTION_STATUS[4:0]: slot_wmask = 8'h17;
      IDX_PROGRAM_COUNTER_UPPER_LATCH[4:0]: slot_wmask = 8'h1F;
      IDX_PERIPHERAL_IRQ_ENABLE_TWO[4:0]: slot_wmask = 8'h01;
      IDX_POWER_RESET_CAUSE_FLAGS[4:0]: slot_wmask = 8'h03;
      IDX_SERIAL_PORT_STATE[4:0]: slot_wmask = 8'hC0;
      IDX_USART_TRANSMIT_CONTROL[4:0]: slot_wmask = 8'hF5;
      IDX_CONVERTER_PIN_CONFIG[4:0]: slot_wmask = 8'h07;
      IDX_TIMER0_AND_PORTB_OPTIONS[4:0], IDX_PROGRAM_COUNTER_LOW[4:0],
      IDX_INDIRECT_POINTER[4:0], IDX_PORT_B_DIRECTION[4:0],
      IDX_PORT_C_DIRECTION[4:0], IDX_FOURTH_PORT_DIRECTION[4:0],
      IDX_INTERRUPT_CONTROL[4:0], IDX_PERIPHERAL_IRQ_ENABLE_ONE[4:0],
      IDX_TIMER2_PERIOD[4:0], IDX_SERIAL_PORT_SLAVE_ADDRESS[4:0],
      IDX_BAUD_RATE_DIVISOR[4:0]: slot_wmask = 8'hFF;
      default: slot_wmask = 8'h00;
    endcase
  endfunction

  // Power-up value; unknown bits are taken as zero
  function automatic logic [7:0] slot_por(input logic [4:0] s);
    case (s)
      IDX_TIMER0_AND_PORTB_OPTIONS[4:0], IDX_PORT_B_DIRECTION[4:0],
      IDX_PORT_C_DIRECTION[4:0], IDX_FOURTH_PORT_DIRECTION[4:0],
      IDX_TIMER2_PERIOD[4:0]: slot_por = 8'hFF;
      IDX_PORT_A_DIRECTION[4:0]: slot_por = 8'h3F;
      IDX_CPU_STATUS_FLAGS[4:0]: slot_por = 8'h18;
      IDX_FIFTH_PORT_DIRECTION_STATUS[4:0]: slot_por = 8'h07;
      default: slot_por = 8'h00;
    endcase
  endfunction

  // Bits left unchanged by a master-clear or watchdog reset
  function automatic logic [7:0] slot_keep(input logic [4:0] s);
    case (s)
      IDX_CPU_STATUS_FLAGS[4:0]: slot_keep = 8'h07;
      IDX_INDIRECT_POINTER[4:0]: slot_keep = 8'hFF;
      IDX_INTERRUPT_CONTROL[4:0]: slot_keep = 8'h01;
      IDX_POWER_RESET_CAUSE_FLAGS[4:0]: slot_keep = 8'h03;
      default: slot_keep = 8'h00;
    endcase
  endfunction

  // Bits left unchanged by a brown-out reset (power-on flag)
  function automatic logic [7:0] slot_bor_keep(input logic [4:0] s);
    slot_bor_keep = (s == IDX_POWER_RESET_CAUSE_FLAGS[4:0]) ?
      8'h02 : 8'h00;
  endfunction

endpackage

// File: design/bsr_apb_port.sv
// APB handshake for the special register bank: one wait state,
// read data captured into a flop. Assumes a well-behaved APB master.
`timescale 1ns/1ps
module bsr_apb_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB control
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Read value of the addressed slot
  input wire logic [7:0] rd_value,
  // APB answer
  output logic pready,
  output logic [31:0] prdata,
  // Write takes effect this edge
  output logic wr_commit
);

  logic pready_ff;
  logic [31:0] prdata_ff;
  logic nxt_pready;
  logic access_wait;

  // Answer one cycle into the access phase, so data comes from a flop
  assign access_wait = psel & penable & ~pready_ff;
  assign nxt_pready = access_wait;
  assign wr_commit = psel & penable & pready_ff & pwrite;
  assign pready = pready_ff;
  assign prdata = prdata_ff;

  // Handshake and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= nxt_pready;
      if (access_wait && !pwrite) begin
        prdata_ff <= {24'h00_0000, rd_value};
      end
    end
  end

endmodule // bsr_apb_port

// File: design/bsr_bank1_regs.sv
// Bank-one special function registers of a small controller core,
// reached by software over APB, with per-cause reset values.
// Assumes the reset controller pulses one reset cause per cycle and
// the data memory answers the indirect port combinationally.
//
// Overview of operation
// - Upper latch moves into PC only on load
// - No address maps the PC upper byte
// - Unimplemented addresses always read as zero
// - Shared registers decode alike from every bank
// - Master-clear and watchdog load other-reset values
// - Without ports four/five, 88h/89h read zero
// - Unknown, unchanged and cause bits reset per code
// - Unimplemented bits inside registers read as zero
`timescale 1ns/1ps
module bsr_bank1_regs #(
  parameter bit HAS_PORTS_DE = 1'b1
) (
  // Clock and reset (reset is power-on)
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bsr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  // Reset causes from the reset controller
  input wire logic master_clear_pin_reset,
  input wire logic watchdog_reset,
  input wire logic brown_out_reset,
  input wire logic reset_time_out_value,
  input wire logic reset_power_down_value,
  // Live peripheral status bits
  input wire logic [2:0] parallel_port_status,
  input wire logic [5:0] serial_port_live_status,
  input wire logic transmit_shift_empty,
  // Indirect data memory access
  input wire logic [7:0] indirect_read_data,
  output logic [8:0] indirect_address,
  output logic indirect_write,
  output logic [7:0] indirect_write_data,
  // Program counter
  output logic [12:0] program_counter,
  // Register contents toward the core and peripherals
  output logic [7:0] timer0_and_portb_options,
  output logic [7:0] cpu_status_flags,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic [7:0] fourth_port_direction,
  output logic [7:0] fifth_port_direction_status,
  output logic [7:0] program_counter_upper_latch,
  output logic [7:0] interrupt_control,
  output logic [7:0] peripheral_irq_enable_one,
  output logic [7:0] peripheral_irq_enable_two,
  output logic [7:0] power_reset_cause_flags,
  output logic [7:0] timer2_period,
  output logic [7:0] serial_port_slave_address,
  output logic [7:0] serial_port_state,
  output logic [7:0] usart_transmit_control,
  output logic [7:0] baud_rate_divisor,
  output logic [7:0] converter_pin_config
);

  // Address split
  logic [bsr_pkg::IDX_W-1:0] word_idx;
  logic [1:0] bank_sel;
  logic [1:0] region_sel;
  logic [bsr_pkg::SLOT_W-1:0] slot_sel;
  logic slot_hit;
  logic slot_impl;
  logic [7:0] slot_wm;

  // Reset causes
  logic other_reset;

  // Slot contents and read path
  logic [7:0] slot_q [bsr_pkg::NUM_SLOTS];
  logic [7:0] live_q [bsr_pkg::NUM_SLOTS];
  logic [7:0] rd_value;
  logic wr_commit;

  // Program counter upper byte and indirect strobe
  logic [bsr_pkg::PROGRAM_COUNTER_UPPER_LATCH_W-1:0] pc_upper_ff;
  logic [bsr_pkg::PROGRAM_COUNTER_UPPER_LATCH_W-1:0] nxt_pc_upper;
  logic indirect_write_ff;
  logic [7:0] indirect_write_data_ff;
  logic pcl_write;
  logic ind_write;

  // Word index from the byte address; low two bits are ignored
  assign word_idx = paddr[bsr_pkg::ADDR_W-1:2];
  assign bank_sel = word_idx[8:7];
  assign region_sel = word_idx[6:5];
  assign slot_sel = word_idx[4:0];

  // Slots present in this build
  function automatic logic present(input logic [4:0] s);
    logic de_slot;
    de_slot = (s == bsr_pkg::IDX_FOURTH_PORT_DIRECTION[4:0]) ||
      (s == bsr_pkg::IDX_FIFTH_PORT_DIRECTION_STATUS[4:0]);
    present = (bsr_pkg::slot_wmask(s) != 8'h00 ||
      s == bsr_pkg::IDX_INDIRECT_ACCESS_PORT[4:0]) &&
      (HAS_PORTS_DE || !de_slot);
  endfunction

  // Shared registers hit from any bank, others only in bank one
  assign slot_hit = (region_sel == bsr_pkg::SFR_REGION) &&
    ((bank_sel == bsr_pkg::BANK_ONE) ||
    bsr_pkg::slot_common(slot_sel));
  assign slot_impl = slot_hit && present(slot_sel);
  assign slot_wm = bsr_pkg::slot_wmask(slot_sel);

  // Master-clear and watchdog share one set of reset values
  assign other_reset = master_clear_pin_reset | watchdog_reset;

  // Bus handshake
  bsr_apb_port u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .rd_value(rd_value),
    .pready(pready),
    .prdata(prdata),
    .wr_commit(wr_commit)
  );

  // Live status bits; the other implemented bits in these slots are stored
  always_comb begin
    for (int k = 0; k < bsr_pkg::NUM_SLOTS; k++) begin
      live_q[k] = 8'h00;
    end
    live_q[bsr_pkg::IDX_FIFTH_PORT_DIRECTION_STATUS[4:0]] =
      HAS_PORTS_DE ?
      {parallel_port_status, 5'h00} : 8'h00;
    live_q[bsr_pkg::IDX_SERIAL_PORT_STATE[4:0]] =
      {2'h0, serial_port_live_status};
    live_q[bsr_pkg::IDX_USART_TRANSMIT_CONTROL[4:0]] =
      {6'h00, transmit_shift_empty, 1'b0};
  end

  // One storage slot per writable implemented location; absent ones and the indirect port are zero
  generate
    for (genvar i = 0; i < bsr_pkg::NUM_SLOTS; i++) begin : g_slot
      localparam logic [4:0] SLOT = 5'(i);
      localparam logic [7:0] WM = bsr_pkg::slot_wmask(SLOT);
      localparam logic [7:0] POR = bsr_pkg::slot_por(SLOT);
      localparam logic [7:0] KEEP = bsr_pkg::slot_keep(SLOT);
      localparam logic [7:0] BKEEP = bsr_pkg::slot_bor_keep(SLOT);
      // Stored read-only bits (time-out, power-down) power up set, so
      // the power-up value marks them as implemented for reads
      localparam logic [7:0] RM = WM | POR;
      if (present(SLOT) && WM != 8'h00) begin : g_store
        logic [7:0] val_ff;
        logic [7:0] nxt_val;
        logic [7:0] other_val;
        logic hit_me;
        assign hit_me = wr_commit && slot_impl && (slot_sel == SLOT);
        // Other resets keep "unchanged" bits, reload the rest
        assign other_val = (val_ff & KEEP) | (POR & ~KEEP);
        always_comb begin
          nxt_val = val_ff;
          if (brown_out_reset) begin
            nxt_val = (val_ff & BKEEP) | (POR & ~BKEEP);
          end else if (other_reset) begin
            nxt_val = other_val;
            if (SLOT == bsr_pkg::IDX_CPU_STATUS_FLAGS[4:0]) begin
              nxt_val[bsr_pkg::STATUS_TO_BIT] = reset_time_out_value;
              nxt_val[bsr_pkg::STATUS_PD_BIT] =
                reset_power_down_value;
            end
          end else if (hit_me) begin
            // Only implemented bits take the write
            nxt_val = (val_ff & ~WM) | (pwdata[7:0] & WM);
          end
        end
        // Power-on reset loads the power-up table
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            val_ff <= POR;
          end else begin
            val_ff <= nxt_val;
          end
        end
        assign slot_q[i] = val_ff & RM;
      end else begin : g_absent
        assign slot_q[i] = 8'h00;
      end
    end
  endgenerate

  // Read path: indirect port reads memory, unmapped places read zero
  assign rd_value = !slot_impl ? 8'h00 :
    (slot_sel == bsr_pkg::IDX_INDIRECT_ACCESS_PORT[4:0]) ?
    indirect_read_data :
    (slot_q[slot_sel] | (live_q[slot_sel] & ~slot_wm));

  // Writes that trigger side effects
  assign pcl_write = wr_commit && slot_impl &&
    (slot_sel == bsr_pkg::IDX_PROGRAM_COUNTER_LOW[4:0]);
  assign ind_write = wr_commit && slot_impl &&
    (slot_sel == bsr_pkg::IDX_INDIRECT_ACCESS_PORT[4:0]);

  // The latch is copied into the upper byte only when PROGRAM_COUNTER_LOW is loaded
  assign nxt_pc_upper = pcl_write ?
    slot_q[bsr_pkg::IDX_PROGRAM_COUNTER_UPPER_LATCH[4:0]]
    [bsr_pkg::PROGRAM_COUNTER_UPPER_LATCH_W-1:0] : pc_upper_ff;

  // Upper program counter bits; no bus address reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_upper_ff <= '0;
    end else if (brown_out_reset || other_reset) begin
      pc_upper_ff <= '0;
    end else begin
      pc_upper_ff <= nxt_pc_upper;
    end
  end

  // Indirect write strobe toward data memory, one cycle long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_write_ff <= 1'b0;
      indirect_write_data_ff <= 8'h00;
    end else begin
      indirect_write_ff <= ind_write;
      if (ind_write) begin
        indirect_write_data_ff <= pwdata[7:0];
      end
    end
  end

  // Outputs taken straight from the storage flops
  assign indirect_write = indirect_write_ff;
  assign indirect_write_data = indirect_write_data_ff;
  assign indirect_address = {
    slot_q[bsr_pkg::IDX_CPU_STATUS_FLAGS[4:0]][bsr_pkg::STATUS_IRP_BIT],
    slot_q[bsr_pkg::IDX_INDIRECT_POINTER[4:0]]};
  assign program_counter = {pc_upper_ff,
    slot_q[bsr_pkg::IDX_PROGRAM_COUNTER_LOW[4:0]]};
  assign timer0_and_portb_options =
    slot_q[bsr_pkg::IDX_TIMER0_AND_PORTB_OPTIONS[4:0]];
  assign cpu_status_flags = slot_q[bsr_pkg::IDX_CPU_STATUS_FLAGS[4:0]];
  assign port_a_direction = slot_q[bsr_pkg::IDX_PORT_A_DIRECTION[4:0]];
  assign port_b_direction = slot_q[bsr_pkg::IDX_PORT_B_DIRECTION[4:0]];
  assign port_c_direction = slot_q[bsr_pkg::IDX_PORT_C_DIRECTION[4:0]];
  assign fourth_port_direction =
    slot_q[bsr_pkg::IDX_FOURTH_PORT_DIRECTION[4:0]];
  assign fifth_port_direction_status =
    slot_q[bsr_pkg::IDX_FIFTH_PORT_DIRECTION_STATUS[4:0]];
  assign program_counter_upper_latch =
    slot_q[bsr_pkg::IDX_PROGRAM_COUNTER_UPPER_LATCH[4:0]];
  assign interrupt_control =
    slot_q[bsr_pkg::IDX_INTERRUPT_CONTROL[4:0]];
  assign peripheral_irq_enable_one =
    slot_q[bsr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_ONE[4:0]];
  assign peripheral_irq_enable_two =
    slot_q[bsr_pkg::IDX_PERIPHERAL_IRQ_ENABLE_TWO[4:0]];
  assign power_reset_cause_flags =
    slot_q[bsr_pkg::IDX_POWER_RESET_CAUSE_FLAGS[4:0]];
  assign timer2_period = slot_q[bsr_pkg::IDX_TIMER2_PERIOD[4:0]];
  assign serial_port_slave_address =
    slot_q[bsr_pkg::IDX_SERIAL_PORT_SLAVE_ADDRESS[4:0]];
  assign serial_port_state = slot_q[bsr_pkg::IDX_SERIAL_PORT_STATE[4:0]];
  assign usart_transmit_control =
    slot_q[bsr_pkg::IDX_USART_TRANSMIT_CONTROL[4:0]];
  assign baud_rate_divisor = slot_q[bsr_pkg::IDX_BAUD_RATE_DIVISOR[4:0]];
  assign converter_pin_config =
    slot_q[bsr_pkg::IDX_CONVERTER_PIN_CONFIG[4:0]];

endmodule // bsr_bank1_regs

// File: dv/bsr_bank1_regs_chk.sv
// Checker for the bank-one register map, watching the top ports only.
// Assumes one APB master and at most one reset-cause pulse at a time.
`timescale 1ns/1ps
module bsr_bank1_regs_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bsr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Reset causes
  input wire logic master_clear_pin_reset,
  input wire logic watchdog_reset,
  input wire logic brown_out_reset,
  // Register contents
  input wire logic [12:0] program_counter,
  input wire logic [7:0] timer0_and_portb_options,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] program_counter_upper_latch,
  input wire logic [7:0] power_reset_cause_flags
);
  // Slot decode; a reset pulse outranks a bus write, so exclude it
  wire [4:0] slot = paddr[6:2];
  wire in_region = (paddr[8:7] == 2'h0);
  wire any_rst = master_clear_pin_reset | watchdog_reset | brown_out_reset;
  wire soft_rst = (master_clear_pin_reset | watchdog_reset) & ~brown_out_reset;
  wire commit = psel & penable & pready & pwrite & ~any_rst & in_region;
  wire pcl_wr = commit & (slot == 5'h02);
  wire latch_wr = commit & (slot == 5'h0A);
  wire hole = (slot inside {5'h0F, 5'h10, 5'h11, 5'h15, 5'h16, 5'h17}) |
    (slot >= 5'h1A && slot <= 5'h1E);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && !penable |->
    !pready [*2] ##1 pready ##1 !pready) else $error("pready timing");
  a_hole_reads_zero: assert property (pready && !pwrite && in_region
    && hole |-> prdata == 32'h0) else $error("hole read not zero");
  a_upper_bytes_zero: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  a_bits_unimpl_zero: assert property (port_a_direction[7:6] == 2'h0 &&
    program_counter_upper_latch[7:5] == 3'h0 &&
    power_reset_cause_flags[7:2] == 6'h0) else $error("unused bit set");
  a_pc_load_latch: assert property (pcl_wr |=> program_counter ==
    {$past(program_counter_upper_latch[4:0]), $past(pwdata[7:0])})
    else $error("pc load wrong");
  a_pc_upper_hold: assert property ($changed(program_counter[12:8]) |->
    $past(any_rst) || $past(pcl_wr)) else $error("pc upper moved");
  a_latch_any_bank: assert property (latch_wr |=>
    program_counter_upper_latch == {3'h0, $past(pwdata[4:0])})
    else $error("latch write lost");
  a_soft_reset_vals: assert property (soft_rst |=>
    program_counter == 13'h0 && port_a_direction == 8'h3F &&
    timer0_and_portb_options == 8'hFF)
    else $error("soft reset values wrong");
  a_cause_flags_kept: assert property (soft_rst |=>
    $stable(power_reset_cause_flags)) else $error("cause flags changed");
  a_brown_out_flags: assert property (brown_out_reset |=>
    power_reset_cause_flags == {6'h0, $past(power_reset_cause_flags[1]),
    1'b0}) else $error("brown-out flags wrong");
  a_hole_write_inert: assert property (commit && hole |=>
    $stable(port_a_direction) && $stable(program_counter_upper_latch) &&
    $stable(program_counter)) else $error("hole write changed state");
  c_pc_load: cover property (pcl_wr);
  c_hole_read: cover property (pready && !pwrite && hole);
  c_soft_rst: cover property (soft_rst);
endmodule // bsr_bank1_regs_chk

bind bsr_bank1_regs bsr_bank1_regs_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .master_clear_pin_reset(master_clear_pin_reset),
  .watchdog_reset(watchdog_reset), .brown_out_reset(brown_out_reset),
  .program_counter(program_counter),
  .timer0_and_portb_options(timer0_and_portb_options),
  .port_a_direction(port_a_direction),
  .program_counter_upper_latch(program_counter_upper_latch),
  .power_reset_cause_flags(power_reset_cause_flags));

// File: dv/bsr_bank1_regs_tb.sv
// Self-checking bench for the bank-one register map over APB.
// Assumes the checker is bound in; bench drives every input itself.
`timescale 1ns/1ps
module bsr_bank1_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, indirect_write;
  logic [bsr_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic master_clear_pin_reset, watchdog_reset, brown_out_reset;
  logic reset_time_out_value, reset_power_down_value, transmit_shift_empty;
  logic [2:0] parallel_port_status;
  logic [5:0] serial_port_live_status;
  logic [7:0] indirect_read_data, indirect_write_data;
  logic [8:0] indirect_address;
  logic [12:0] program_counter;
  logic pready_nd;
  logic [31:0] prdata_nd, rd_nd;
  logic [7:0] status_o, fifth_o, ssp_o, tx_o;
  int failures, compares;
  // Expected power-up reads, and reads after writing ones everywhere but bit 7 of slot 12
  logic [7:0] por_tab [32] = '{8'h00, 8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F,
    8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ff_tab [32] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
    8'hFF, 8'hFF, 8'hFF, 8'hB7, 8'h1F, 8'hFF, 8'h7F, 8'h01, 8'h03, 8'h00,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'hEA, 8'h00, 8'h00, 8'h00, 8'hF5, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};

  bsr_bank1_regs u_bsr_bank1_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .master_clear_pin_reset(master_clear_pin_reset),
    .watchdog_reset(watchdog_reset), .brown_out_reset(brown_out_reset),
    .reset_time_out_value(reset_time_out_value),
    .reset_power_down_value(reset_power_down_value),
    .parallel_port_status(parallel_port_status),
    .serial_port_live_status(serial_port_live_status),
    .transmit_shift_empty(transmit_shift_empty),
    .indirect_read_data(indirect_read_data),
    .indirect_address(indirect_address), .indirect_write(indirect_write),
    .indirect_write_data(indirect_write_data),
    .program_counter(program_counter), .timer0_and_portb_options(),
    .cpu_status_flags(status_o), .port_a_direction(), .port_b_direction(),
    .port_c_direction(), .fourth_port_direction(),
    .fifth_port_direction_status(fifth_o), .program_counter_upper_latch(),
    .interrupt_control(), .peripheral_irq_enable_one(),
    .peripheral_irq_enable_two(), .power_reset_cause_flags(),
    .timer2_period(), .serial_port_slave_address(),
    .serial_port_state(ssp_o), .usart_transmit_control(tx_o),
    .baud_rate_divisor(), .converter_pin_config());

  // Build without ports four and five, listening on the same bus
  bsr_bank1_regs #(.HAS_PORTS_DE(1'b0)) u_bsr_bank1_regs_nd (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready_nd),
    .prdata(prdata_nd), .master_clear_pin_reset(master_clear_pin_reset),
    .watchdog_reset(watchdog_reset), .brown_out_reset(brown_out_reset),
    .reset_time_out_value(reset_time_out_value),
    .reset_power_down_value(reset_power_down_value),
    .parallel_port_status(parallel_port_status),
    .serial_port_live_status(serial_port_live_status),
    .transmit_shift_empty(transmit_shift_empty),
    .indirect_read_data(indirect_read_data), .indirect_address(),
    .indirect_write(), .indirect_write_data(), .program_counter(),
    .timer0_and_portb_options(), .cpu_status_flags(), .port_a_direction(),
    .port_b_direction(), .port_c_direction(), .fourth_port_direction(),
    .fifth_port_direction_status(), .program_counter_upper_latch(),
    .interrupt_control(), .peripheral_irq_enable_one(),
    .peripheral_irq_enable_two(), .power_reset_cause_flags(),
    .timer2_period(), .serial_port_slave_address(), .serial_port_state(),
    .usart_transmit_control(), .baud_rate_divisor(),
    .converter_pin_config());

  // Free-running 250 MHz clock
  always #2 pclk = ~pclk;

  task summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready rather than assuming a latency
  task apb(input logic [8:0] idx, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    // Variant's read; bit 31 marks a ready out of step with the main one
    rd_nd = prdata_nd | {pready ^ pready_nd, 31'h0};
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask

  task rchk(input logic [8:0] idx, input logic [7:0] e);
    apb(idx, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // Reset-cause pulse of one cycle with the levels it loads
  task pulse(input logic [2:0] v, input logic [1:0] tp);
    @(posedge pclk);
    {brown_out_reset, watchdog_reset, master_clear_pin_reset} <= v;
    {reset_time_out_value, reset_power_down_value} <= tp;
    @(posedge pclk);
    {brown_out_reset, watchdog_reset, master_clear_pin_reset} <= 3'h0;
    // Let the reset values land before anyone looks at them
    @(posedge pclk);
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {master_clear_pin_reset, watchdog_reset, brown_out_reset} = 3'h0;
    {reset_time_out_value, reset_power_down_value} = 2'h0;
    {parallel_port_status, serial_port_live_status} = 9'h000;
    transmit_shift_empty = 1'b1;
    indirect_read_data = 8'h00;
    failures = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Power-up values of every slot, holes included
    for (int s = 0; s < 32; s++) rchk(9'(9'h080 + s), por_tab[s]);
    // Live bits move, then ones written everywhere; parallel enable clear
    parallel_port_status <= 3'h5;
    serial_port_live_status <= 6'h2A;
    transmit_shift_empty <= 1'b0;
    for (int s = 0; s < 32; s++)
      apb(9'(9'h080 + s), 1'b1, (s == 12) ? 8'h7F : 8'hFF);
    for (int s = 0; s < 32; s++) rchk(9'(9'h080 + s), ff_tab[s]);
    // Register outputs carry stored bits only, live bits left out
    chk({status_o, fifth_o, ssp_o, tx_o}, 32'hFF17C0F5);
    apb(9'h088, 1'b0, 8'h00);
    chk(rd_nd, 32'h0);
    apb(9'h089, 1'b0, 8'h00);
    chk(rd_nd, 32'h0);
    // Indirect port through two banks
    apb(9'h080, 1'b1, 8'h3C);
    @(posedge pclk);
    chk({14'h0, indirect_write, indirect_address, indirect_write_data},
      32'h0003FF3C);
    indirect_read_data <= 8'hA5;
    rchk(9'h180, 8'hA5);
    // Latch through bank three and two, PC load through bank zero
    apb(9'h18A, 1'b1, 8'hF5);
    rchk(9'h10A, 8'h15);
    apb(9'h002, 1'b1, 8'h3C);
    @(posedge pclk);
    chk({19'h0, program_counter}, 32'h0000153C);
    apb(9'h08A, 1'b1, 8'h0A);
    @(posedge pclk);
    chk({19'h0, program_counter}, 32'h0000153C);
    rchk(9'h082, 8'h3C);
    rchk(9'h105, 8'h00);
    rchk(9'h1E0, 8'h00);
    // Master clear, then watchdog, then brown-out
    apb(9'h085, 1'b1, 8'h00);
    apb(9'h081, 1'b1, 8'h00);
    pulse(3'h1, 2'h2);
    chk({19'h0, program_counter}, 32'h0);
    rchk(9'h083, 8'h17);
    rchk(9'h084, 8'hFF);
    rchk(9'h08B, 8'h01);
    rchk(9'h08E, 8'h03);
    rchk(9'h081, 8'hFF);
    rchk(9'h085, 8'h3F);
    pulse(3'h2, 2'h1);
    rchk(9'h083, 8'h0F);
    pulse(3'h4, 2'h0);
    rchk(9'h083, 8'h18);
    rchk(9'h084, 8'h00);
    rchk(9'h08B, 8'h00);
    rchk(9'h08E, 8'h02);
    summarize();
  end
endmodule // bsr_bank1_regs_tb
